/* File: logic/adc_ch123_input_select.sv */
/*
  Input selection for converter sample channels 1 to 3: APB register
  file, 12-bit mode masking, sample A/B alternation and registered mux
  selects for the analog front end.
  Assumes APB4 signalling synchronous to ref_clk and a one-cycle
  sampleStart pulse from the converter at the start of each sample.
*/
// Added by the designer: register access over APB and the register offsets.
// Overview of operation
// - bits 15-11 and 7-3 of the select register read zero, writes ignored
// - group B negative field 11 picks inputs 9/10/11, 10 picks 6/7/8
// - group B positive bit picks inputs 3/4/5 when set, else 0/1/2
// - group A negative field decodes like group B: 9-11, 6-8, else ref
// - group A positive bit picks inputs 3/4/5 when one, else 0/1/2
// - in 12-bit mode both negative fields read zero and ignore writes
// - in 12-bit mode both positive bits read zero as well
`timescale 1ns/1ps
module adc_ch123_input_select import adc_sel_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sampleStart,
  output logic groupBActive,
  output logic [3:0] sampleChannel1PosSel,
  output logic [3:0] sampleChannel1NegSel,
  output logic [3:0] sampleChannel2PosSel,
  output logic [3:0] sampleChannel2NegSel,
  output logic [3:0] sampleChannel3PosSel,
  output logic [3:0] sampleChannel3NegSel
);

  logic [15:0] selStore_reg;
  logic twelveBitMode_reg;
  logic altSample_reg;
  logic groupB_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  logic setupPhase;
  logic accessDone;
  logic wrSel;
  logic wrCtrl;
  logic mapped;
  logic [15:0] selVisible;
  logic [15:0] selWriteMask;
  logic [15:0] selStore_next;
  logic [31:0] readValue;

  logic groupAPos;
  logic [1:0] groupANeg;
  logic groupBPos;
  logic [1:0] groupBNeg;
  logic activePos;
  logic [1:0] activeNeg;
  logic [3:0] posSel1;
  logic [3:0] negSel1;
  logic [3:0] posSel2;
  logic [3:0] negSel2;
  logic [3:0] posSel3;
  logic [3:0] negSel3;

  // bus phases
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready_reg;
  assign wrSel = accessDone && pwrite && (paddr == SEL_OFS);
  assign wrCtrl = accessDone && pwrite && (paddr == CTRL_OFS);

  // fields vanish while the converter is in 12-bit mode
  always_comb begin
    if (twelveBitMode_reg) begin
      selVisible = 16'h0000;
    end else begin
      selVisible = selStore_reg & SEL_WMASK;
    end
  end

  // byte lanes gate the two implemented bytes
  always_comb begin
    selWriteMask = SEL_WMASK;
    if (!pstrb[0]) begin
      selWriteMask[7:0] = 8'h00;
    end
    if (!pstrb[1]) begin
      selWriteMask[15:8] = 8'h00;
    end
    if (twelveBitMode_reg) begin
      selWriteMask = 16'h0000;
    end
  end

  assign selStore_next = (selStore_reg & ~selWriteMask)
    | (pwdata[15:0] & selWriteMask);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      selStore_reg <= SEL_RESET;
    end else if (wrSel) begin
      selStore_reg <= selStore_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      twelveBitMode_reg <= TWELVE_BIT_RESET;
      altSample_reg <= ALT_SAMPLE_RESET;
    end else if (wrCtrl && pstrb[0]) begin
      twelveBitMode_reg <= pwdata[TWELVE_BIT_BIT];
      altSample_reg <= pwdata[ALT_SAMPLE_BIT];
    end
  end

  // read data and decode, formed in the setup cycle
  always_comb begin
    readValue = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == SEL_OFS) begin
      readValue[15:0] = selVisible;
    end else if (paddr == CTRL_OFS) begin
      readValue[TWELVE_BIT_BIT] = twelveBitMode_reg;
      readValue[ALT_SAMPLE_BIT] = altSample_reg;
    end else if (paddr == STAT_OFS) begin
      readValue[STAT_GROUP_B_BIT] = groupB_reg;
      readValue[STAT_TWELVE_BIT] = twelveBitMode_reg;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setupPhase) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : readValue;
      pslverr_reg <= !mapped;
    end else if (accessDone) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
  end

  // one access cycle per transfer, no wait states
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setupPhase;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // sample group alternation
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      groupB_reg <= GROUP_B_RESET;
    end else if (!altSample_reg) begin
      groupB_reg <= 1'b0;
    end else if (sampleStart) begin
      groupB_reg <= !groupB_reg;
    end
  end

  assign groupAPos = selVisible[GROUP_A_POS_BIT];
  assign groupANeg = selVisible[GROUP_A_NEG_LSB +: 2];
  assign groupBPos = selVisible[GROUP_B_POS_BIT];
  assign groupBNeg = selVisible[GROUP_B_NEG_LSB +: 2];

  // group A unless alternation has moved to group B
  assign activePos = groupB_reg ? groupBPos : groupAPos;
  assign activeNeg = groupB_reg ? groupBNeg : groupANeg;

  chan_select_decode #(.CHAN_OFS(4'h0)) decodeChannel1 (
    .posBit(activePos),
    .negCode(activeNeg),
    .posSel(posSel1),
    .negSel(negSel1)
  );

  chan_select_decode #(.CHAN_OFS(4'h1)) decodeChannel2 (
    .posBit(activePos),
    .negCode(activeNeg),
    .posSel(posSel2),
    .negSel(negSel2)
  );

  chan_select_decode #(.CHAN_OFS(4'h2)) decodeChannel3 (
    .posBit(activePos),
    .negCode(activeNeg),
    .posSel(posSel3),
    .negSel(negSel3)
  );

  // registered mux selects
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sampleChannel1PosSel <= POS_LOW_BASE;
      sampleChannel1NegSel <= NEG_VREF_CODE;
      sampleChannel2PosSel <= POS_LOW_BASE + 4'h1;
      sampleChannel2NegSel <= NEG_VREF_CODE;
      sampleChannel3PosSel <= POS_LOW_BASE + 4'h2;
      sampleChannel3NegSel <= NEG_VREF_CODE;
    end else begin
      sampleChannel1PosSel <= posSel1;
      sampleChannel1NegSel <= negSel1;
      sampleChannel2PosSel <= posSel2;
      sampleChannel2NegSel <= negSel2;
      sampleChannel3PosSel <= posSel3;
      sampleChannel3NegSel <= negSel3;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      groupBActive <= GROUP_B_RESET;
    end else begin
      groupBActive <= groupB_reg;
    end
  end

endmodule

/* File: logic/adc_sel_pkg.sv */
/*
  Shared constants for the channel 1-3 input select block: register
  offsets, field positions, reset values and mux select codes.
  Assumes an APB slave port with 12-bit byte addresses and 32-bit data.
*/
package adc_sel_pkg;

  // register byte offsets
  localparam logic [11:0] SEL_OFS = 12'h000;
  localparam logic [11:0] CTRL_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;

  // input select register fields
  localparam int GROUP_A_POS_BIT = 0;
  localparam int GROUP_A_NEG_LSB = 1;
  localparam int GROUP_B_POS_BIT = 8;
  localparam int GROUP_B_NEG_LSB = 9;

  // control register fields
  localparam int TWELVE_BIT_BIT = 0;
  localparam int ALT_SAMPLE_BIT = 1;

  // status register fields
  localparam int STAT_GROUP_B_BIT = 0;
  localparam int STAT_TWELVE_BIT = 1;

  // values after reset
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic TWELVE_BIT_RESET = 1'b0;
  localparam logic ALT_SAMPLE_RESET = 1'b0;
  localparam logic GROUP_B_RESET = 1'b0;

  // writable bits of the input select register
  localparam logic [15:0] SEL_WMASK = 16'h0707;

  // analog input numbers of channel 1; channels 2 and 3 add 1 and 2
  localparam logic [3:0] POS_LOW_BASE = 4'h0;
  localparam logic [3:0] POS_HIGH_BASE = 4'h3;
  localparam logic [3:0] NEG_MID_BASE = 4'h6;
  localparam logic [3:0] NEG_HIGH_BASE = 4'h9;
  // negative mux code for the negative voltage reference
  localparam logic [3:0] NEG_VREF_CODE = 4'hf;

  // negative select field codes
  localparam logic [1:0] NEG_CODE_HIGH = 2'h3;
  localparam logic [1:0] NEG_CODE_MID = 2'h2;

endpackage

/* File: logic/chan_select_decode.sv */
/*
  Decodes one sample group's positive bit and negative field into the
  analog mux select codes of one sample channel.
  Assumes the channel offset is 0, 1 or 2 for channels 1, 2 and 3.
*/
`timescale 1ns/1ps
module chan_select_decode import adc_sel_pkg::*; #(
  parameter logic [3:0] CHAN_OFS = 4'h0
) (
  input wire logic posBit,
  input wire logic [1:0] negCode,
  output logic [3:0] posSel,
  output logic [3:0] negSel
);

  always_comb begin
    // inputs 3/4/5 when set, 0/1/2 when clear
    if (posBit) begin
      posSel = POS_HIGH_BASE + CHAN_OFS;
    end else begin
      posSel = POS_LOW_BASE + CHAN_OFS;
    end
  end

  always_comb begin
    // code 10 is decoded as written; software keeps it off small parts
    if (negCode == NEG_CODE_HIGH) begin
      negSel = NEG_HIGH_BASE + CHAN_OFS;
    end else if (negCode == NEG_CODE_MID) begin
      negSel = NEG_MID_BASE + CHAN_OFS;
    end else begin
      negSel = NEG_VREF_CODE;
    end
  end

endmodule

/* File: verification/adc_ch123_input_select_props.sv */
/* Checker for the channel 1-3 input select block.
   Bound to adc_ch123_input_select; sees its ports only. */
`timescale 1ns/1ps
module adc_ch123_input_select_props import adc_sel_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic groupBActive,
  input wire logic [3:0] sampleChannel1PosSel,
  input wire logic [3:0] sampleChannel2PosSel,
  input wire logic [3:0] sampleChannel3PosSel,
  input wire logic [3:0] sampleChannel1NegSel,
  input wire logic [3:0] sampleChannel2NegSel,
  input wire logic [3:0] sampleChannel3NegSel
);
  logic [3:0] p1, p2, p3, n1, n2, n3;
  logic wr, rd, mode_reg, alt_reg;
  assign {p1, p2, p3} = {sampleChannel1PosSel, sampleChannel2PosSel,
    sampleChannel3PosSel};
  assign {n1, n2, n3} = {sampleChannel1NegSel, sampleChannel2NegSel,
    sampleChannel3NegSel};
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;
  // mirror of the mode bits
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_reg <= 1'b0;
      alt_reg <= 1'b0;
    end else if (wr && paddr == CTRL_OFS && pstrb[0]) begin
      mode_reg <= pwdata[TWELVE_BIT_BIT];
      alt_reg <= pwdata[ALT_SAMPLE_BIT];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_rsv_zero: assert property (rd && paddr == SEL_OFS |->
    prdata[15:11] == 5'h00 && prdata[7:3] == 5'h00) else $error("rsv");
  a_pos_map: assert property ((p1 == 4'h0 || p1 == 4'h3)
    && p2 == p1 + 4'h1 && p3 == p1 + 4'h2) else $error("pos map");
  a_neg_map: assert property (n1 == 4'h6 || n1 == 4'h9
    || n1 == 4'hf) else $error("neg map");
  a_neg_chan: assert property (n1 == 4'hf ? n2 == n1 && n3 == n1 :
    n2 == n1 + 4'h1 && n3 == n1 + 4'h2) else $error("neg chan");
  a_mode_read: assert property (rd && paddr == SEL_OFS && mode_reg
    |-> prdata == 32'h0) else $error("mode read");
  a_mode_sel: assert property (mode_reg && $past(mode_reg)
    |-> p1 == 4'h0 && n1 == 4'hf) else $error("mode sel");
  a_write_group_a: assert property (wr && paddr == SEL_OFS
    && pstrb[0] && !mode_reg && !alt_reg && !groupBActive
    |-> ##2 p1 == ($past(pwdata[0], 2) ? 4'h3 : 4'h0)) else $error("wr a");
  a_default_a: assert property (!alt_reg && !$past(alt_reg)
    && !$past(alt_reg, 2) |-> !groupBActive) else $error("grp a");
  c_sel_write: cover property (wr && paddr == SEL_OFS);
  c_group_b: cover property (groupBActive && !mode_reg);
  c_mode_read: cover property (rd && mode_reg);
endmodule
bind adc_ch123_input_select adc_ch123_input_select_props props (.ref_clk,
  .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
  .pready, .groupBActive, .sampleChannel1PosSel, .sampleChannel2PosSel,
  .sampleChannel3PosSel, .sampleChannel1NegSel, .sampleChannel2NegSel,
  .sampleChannel3NegSel);

/* File: verification/adc_ch123_input_select_tb.sv */
/* Self-checking bench for the channel 1-3 input select block.
   Drives APB and sampleStart directly; no partner model. */
`timescale 1ns/1ps
module adc_ch123_input_select_tb import adc_sel_pkg::*; ;
  logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, sampleStart = 1'b0, pready, pslverr, rerr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [3:0] pstrb = 4'h0;
  logic groupBActive;
  logic [3:0] sampleChannel1PosSel, sampleChannel2PosSel;
  logic [3:0] sampleChannel3PosSel, sampleChannel1NegSel;
  logic [3:0] sampleChannel2NegSel, sampleChannel3NegSel;
  int nFail = 0, checked = 0, cyc = 0;
  adc_ch123_input_select dut (.ref_clk, .sys_rst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sampleStart,
    .groupBActive, .sampleChannel1PosSel,
    .sampleChannel1NegSel, .sampleChannel2PosSel, .sampleChannel2NegSel,
    .sampleChannel3PosSel, .sampleChannel3NegSel);
  initial forever #25 ref_clk = ~ref_clk;
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      nFail++;
      tally_and_finish;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task pulse;
    @(posedge ref_clk);
    sampleStart <= 1'b1;
    @(posedge ref_clk);
    sampleStart <= 1'b0;
    settle;
  endtask
  task sel(input logic p, input logic [1:0] n);
    logic [3:0] b;
    b = n == 2'h3 ? 4'h9 : (n == 2'h2 ? 4'h6 : 4'hf);
    chk(sampleChannel1PosSel, p ? 4'h3 : 4'h0);
    chk(sampleChannel2PosSel, p ? 4'h4 : 4'h1);
    chk(sampleChannel3PosSel, p ? 4'h5 : 4'h2);
    chk(sampleChannel1NegSel, b);
    chk(sampleChannel2NegSel, b == 4'hf ? b : b + 4'h1);
    chk(sampleChannel3NegSel, b == 4'hf ? b : b + 4'h2);
  endtask
  initial begin
    logic [31:0] d;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, SEL_OFS, 32'h0, 4'h0);
    chk(rdat, 32'h0);
    settle;
    sel(1'b0, 2'h0);
    apb(1'b1, SEL_OFS, 32'hffff, 4'h3);
    apb(1'b0, SEL_OFS, 32'h0, 4'h0);
    chk(rdat, 32'h0707);
    settle;
    sel(1'b1, 2'h3);
    $display("test reset_and_mask done");
    apb(1'b1, CTRL_OFS, 32'h2, 4'h1);
    for (int k = 0; k < 8; k++) begin // code 10 legal here
      d = 32'hf8f8 | 32'(k * 256 + 7 - k);
      apb(1'b1, SEL_OFS, d, 4'h3);
      apb(1'b0, SEL_OFS, 32'h0, 4'h0);
      chk(rdat, d & 32'h0707);
      settle;
      sel(d[0], d[2:1]);
      pulse;
      chk(groupBActive, 1'b1);
      apb(1'b0, STAT_OFS, 32'h0, 4'h0);
      chk(rdat, 32'h1);
      sel(d[8], d[10:9]);
      pulse;
      chk(groupBActive, 1'b0);
    end
    $display("test groups done");
    apb(1'b1, CTRL_OFS, 32'h1, 4'h1);
    apb(1'b0, CTRL_OFS, 32'h0, 4'h0);
    chk(rdat, 32'h1);
    apb(1'b0, STAT_OFS, 32'h0, 4'h0);
    chk(rdat, 32'h2);
    apb(1'b0, SEL_OFS, 32'h0, 4'h0);
    chk(rdat, 32'h0);
    settle;
    sel(1'b0, 2'h0);
    apb(1'b1, SEL_OFS, 32'h0007, 4'h3);
    apb(1'b1, CTRL_OFS, 32'h0, 4'h1);
    apb(1'b0, SEL_OFS, 32'h0, 4'h0);
    chk(rdat, 32'h0700);
    apb(1'b1, SEL_OFS, 32'hffff, 4'h1);
    apb(1'b0, SEL_OFS, 32'h0, 4'h0);
    chk(rdat, 32'h0707);
    apb(1'b0, 12'h00c, 32'h0, 4'h0);
    chk(rerr, 1'b1);
    $display("test mode_and_errors done");
    tally_and_finish;
  end
endmodule
